// ==== core/lintc_pkg.sv ====
// shared constants, modes and carrier structs of the transceiver controller
// assumes a 200 MHz reference clock on every module that imports it
`default_nettype none
package lintc_pkg;
  // reference clock period in ns
  localparam int unsigned CLK_NS = 5;
  // re-arm time, least: strictly longer than the printed figure
  localparam int unsigned T_REARM_NS = 10000;
  localparam int unsigned REARM_CYC = (T_REARM_NS + CLK_NS - 1) / CLK_NS + 1;
  // dominant time-out of the device, longest low we may ever drive
  localparam int unsigned T_DOM_MS = 20;
  localparam int unsigned DOM_CYC = T_DOM_MS * 1000000 / CLK_NS;
  // one bit time at 20 kbaud
  localparam int unsigned T_BIT_NS = 50000;
  localparam int unsigned BIT_CYC = T_BIT_NS / CLK_NS;
  // counter width shared by all timers
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

  // controller modes, mirroring the device modes
  typedef enum logic [2:0] {
    LINTC_FAILSAFE,
    LINTC_ARM,
    LINTC_NORMAL,
    LINTC_PRESLEEP,
    LINTC_SLEEP
  } lintc_mode_t;

  // wake / fail-safe source as read back from the pins
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_BUS = 2'h1;
  localparam logic [1:0] SRC_LOCAL = 2'h2;
  localparam logic [1:0] SRC_UNDERV = 2'h3;

  // pins we drive toward the device
  typedef struct packed {
    logic en;      // mode enable
    logic txd_o;   // transmit pin level
    logic txd_oe;  // transmit pin enable, high while we drive
  } lintc_pin_out_t;

  // pins we read from the device
  typedef struct packed {
    logic txd;  // transmit pin as seen on the wire
    logic rxd;  // receive pin, pulled up outside
    logic regulator_inhibit_output;  // regulator inhibit level
  } lintc_pin_in_t;
endpackage
`default_nettype wire

// ==== core/lintc_buf2.sv ====
// two-entry valid/ready buffer for transmit bits
// assumes one clock; in_ready comes straight from a flip-flop
`default_nettype none
module lintc_buf2 #(
  parameter int unsigned W = 1
) (
  input wire logic ref_clk,        // reference clock
  input wire logic reset_n,        // async reset, active low
  input wire logic in_valid,       // writer offers a word
  input wire logic [W-1:0] in_data, // offered word
  output logic in_ready,           // room for a word
  output logic out_valid,          // a word is waiting
  output logic [W-1:0] out_data,   // oldest word
  input wire logic out_ready       // reader takes the word
);
  typedef struct packed {
    logic [W-1:0] e0;
    logic [W-1:0] e1;
    logic [1:0] cnt;
    logic room;
  } lintc_buf_st_t;

  lintc_buf_st_t st_ff, nxt_st;
  logic push, pop;

  //////////////////////////////////////////////////////////////////////////
  // handshakes; e0 is always the oldest word
  assign push = in_valid && st_ff.room;
  assign pop = out_ready && (st_ff.cnt != 2'h0);
  assign in_ready = st_ff.room;
  assign out_valid = (st_ff.cnt != 2'h0);
  assign out_data = st_ff.e0;

  // next state: shift on pop, write behind the last word on push
  always_comb begin
    nxt_st = st_ff;
    if (pop) begin
      nxt_st.e0 = st_ff.e1;
      nxt_st.cnt = st_ff.cnt - 2'h1;
    end
    if (push) begin
      if (nxt_st.cnt == 2'h0) begin
        nxt_st.e0 = in_data;
      end else begin
        nxt_st.e1 = in_data;
      end
      nxt_st.cnt = nxt_st.cnt + 2'h1;
    end
    // room registered so the writer sees a flop, not a gate chain
    nxt_st.room = (nxt_st.cnt != 2'h2);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{e0: '0, e1: '0, cnt: 2'h0, room: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // a full buffer never accepts
  chk_buf_no_over: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_ff.cnt == 2'h2) |-> !in_ready)
    else $error("buffer offered room while full");
endmodule
`default_nettype wire

// ==== core/lintc_ctrl.sv ====
// host-side controller for a single-wire bus transceiver: drives mode
// enable and transmit pin, reads receive, inhibit and fail-safe coding
// assumes pin inputs already synchronous to ref_clk
//
// Function
// - transmit low dominant, high recessive
// - hold transmit high over 10us first
// - after time-out, high over 10us re-arms
// - enable falls with transmit high: sleep
// - fail-safe until enable high, then normal
`default_nettype none
module lintc_ctrl
  import lintc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = lintc_pkg::BIT_CYC,
  parameter int unsigned DOM_CYCLES = lintc_pkg::DOM_CYC
) (
  input wire logic ref_clk,                  // 200 MHz reference
  input wire logic reset_n,                  // async reset, active low
  input wire logic cmd_normal,               // pulse: go to normal mode
  input wire logic cmd_sleep,                // pulse: go to sleep mode
  input wire logic tx_valid,                 // a bit to send
  input wire logic tx_data,                  // 0 dominant, 1 recessive
  output logic tx_ready,                     // buffer has room
  output logic rx_level,                     // bus level seen on receive
  output logic link_ready,                   // normal mode, armed
  output logic dom_timeout,                  // a bit was cut at 20 ms
  output logic [1:0] wake_src,               // fail-safe source code
  output lintc_pkg::lintc_pin_out_t pin_out, // pins toward device
  input wire lintc_pkg::lintc_pin_in_t pin_in // pins from device
);
  import lintc_pkg::*;

  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] DOM_MAX = CNT_W'(DOM_CYCLES);
  localparam logic [CNT_W-1:0] REARM_LAST = CNT_W'(REARM_CYC - 1);

  typedef struct packed {
    lintc_mode_t mode;
    lintc_pin_out_t pins;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] dom_cnt;
    logic busy;
    logic [1:0] src;
    logic rx;
    logic ready;
    logic tmo;
    logic inh_off;
  } lintc_st_t;

  localparam lintc_st_t ST_RST = '{
    mode: LINTC_FAILSAFE,
    pins: '{en: 1'b0, txd_o: 1'b1, txd_oe: 1'b0},
    cnt: CNT_ZERO,
    dom_cnt: CNT_ZERO,
    busy: 1'b0,
    src: SRC_NONE,
    rx: 1'b1,
    ready: 1'b0,
    tmo: 1'b0,
    inh_off: 1'b0
  };

  lintc_st_t st_ff, nxt_st;
  logic buf_valid, buf_data, buf_pop;

  ////////////////////////////////////////////////////////////////////////////
  // transmit bits wait here so a busy bit slot stalls the writer, not drops
  lintc_buf2 #(.W(1)) u_txbuf (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_valid(tx_valid),
    .in_data(tx_data),
    .in_ready(tx_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencing and bit timing
  always_comb begin
    nxt_st = st_ff;
    buf_pop = 1'b0;
    case (st_ff.mode)
      LINTC_FAILSAFE: begin
        nxt_st.pins = '{en: 1'b0, txd_o: 1'b1, txd_oe: 1'b0};
        // transmit pin is the device's, read the source code
        case ({pin_in.txd, pin_in.rxd})
          2'b00: nxt_st.src = SRC_BUS;
          2'b01: nxt_st.src = SRC_LOCAL;
          2'b10: nxt_st.src = SRC_UNDERV;
          default: nxt_st.src = SRC_NONE;
        endcase
        // raise enable and start driving transmit high on the same edge
        if (cmd_normal) begin
          nxt_st.mode = LINTC_ARM;
          nxt_st.pins = '{en: 1'b1, txd_o: 1'b1, txd_oe: 1'b1};
          nxt_st.cnt = CNT_ZERO;
          nxt_st.src = SRC_NONE;
        end
      end
      LINTC_ARM: begin
        // recessive for longer than the re-arm time
        nxt_st.pins.txd_o = 1'b1;
        if (st_ff.cnt == REARM_LAST) begin
          nxt_st.mode = LINTC_NORMAL;
          nxt_st.ready = 1'b1;
          nxt_st.cnt = CNT_ZERO;
        end else begin
          nxt_st.cnt = st_ff.cnt + CNT_ONE;
        end
      end
      LINTC_NORMAL: begin
        if (st_ff.busy) begin
          // cut a dominant before the device trips, then re-arm
          if (st_ff.dom_cnt == DOM_MAX) begin
            nxt_st.pins.txd_o = 1'b1;
            nxt_st.busy = 1'b0;
            nxt_st.tmo = 1'b1;
            nxt_st.ready = 1'b0;
            nxt_st.mode = LINTC_ARM;
            nxt_st.cnt = CNT_ZERO;
          end else if (st_ff.cnt == BIT_LAST) begin
            // idle slot returns the bus to recessive
            nxt_st.pins.txd_o = 1'b1;
            nxt_st.busy = 1'b0;
          end else begin
            nxt_st.cnt = st_ff.cnt + CNT_ONE;
          end
        end else if (cmd_sleep) begin
          // transmit set high one cycle ahead of the enable edge
          nxt_st.pins.txd_o = 1'b1;
          nxt_st.ready = 1'b0;
          nxt_st.mode = LINTC_PRESLEEP;
        end else if (buf_valid) begin
          // low drives dominant, high leaves recessive
          buf_pop = 1'b1;
          nxt_st.pins.txd_o = buf_data;
          nxt_st.busy = 1'b1;
          nxt_st.tmo = 1'b0;
          nxt_st.cnt = CNT_ZERO;
        end
      end
      LINTC_PRESLEEP: begin
        // enable falls while transmit is still driven high
        nxt_st.pins.en = 1'b0;
        nxt_st.inh_off = 1'b0;
        nxt_st.mode = LINTC_SLEEP;
      end
      LINTC_SLEEP: begin
        // enable low, pin released; device keeps recessive
        nxt_st.pins = '{en: 1'b0, txd_o: 1'b1, txd_oe: 1'b0};
        if (cmd_normal) begin
          nxt_st.mode = LINTC_ARM;
          nxt_st.pins = '{en: 1'b1, txd_o: 1'b1, txd_oe: 1'b1};
          nxt_st.cnt = CNT_ZERO;
        end else if (st_ff.inh_off && pin_in.regulator_inhibit_output) begin
          // inhibit back on means a wake-up, device is fail-safe
          nxt_st.mode = LINTC_FAILSAFE;
        end
        // the device drops inhibit only after it has seen enable fall,
        // so a wake counts once the pin has been seen off while asleep
        if (!pin_in.regulator_inhibit_output) begin
          nxt_st.inh_off = 1'b1;
        end
      end
      default: begin
        nxt_st = ST_RST;
      end
    endcase
    // length of the current driven low level
    if (nxt_st.pins.txd_oe && !nxt_st.pins.txd_o) begin
      nxt_st.dom_cnt = st_ff.dom_cnt + CNT_ONE;
    end else begin
      nxt_st.dom_cnt = CNT_ZERO;
    end
    // receive only means bus level while the transceiver is on
    nxt_st.rx = (nxt_st.mode == LINTC_NORMAL) ? pin_in.rxd : 1'b1;
  end

  // single state register; reset mirrors the device's power-up fail-safe
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign pin_out = st_ff.pins;
  assign rx_level = st_ff.rx;
  assign link_ready = st_ff.ready;
  assign dom_timeout = st_ff.tmo;
  assign wake_src = st_ff.src;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_idle_recessive: assert property (@(posedge ref_clk)
    disable iff (!reset_n)
    (st_ff.mode == LINTC_NORMAL && !st_ff.busy) |-> st_ff.pins.txd_o)
    else $error("transmit low with no bit in flight");
  chk_arm_then_normal: assert property (@(posedge ref_clk)
    disable iff (!reset_n)
    $rose(st_ff.mode == LINTC_NORMAL) |->
      $past(st_ff.mode) == LINTC_ARM && $past(st_ff.cnt) == REARM_LAST)
    else $error("normal reached before re-arm time");
  chk_rise_en_high: assert property (@(posedge ref_clk)
    disable iff (!reset_n)
    $rose(st_ff.pins.en) |->
      (st_ff.pins.txd_o && st_ff.pins.txd_oe && st_ff.src == SRC_NONE) [*8])
    else $error("enable rose without transmit held high");
  chk_dom_bound: assert property (@(posedge ref_clk)
    disable iff (!reset_n)
    st_ff.dom_cnt <= DOM_MAX)
    else $error("dominant driven past the time-out");
  chk_tmo_rearm: assert property (@(posedge ref_clk)
    disable iff (!reset_n)
    $rose(st_ff.tmo) |-> st_ff.mode == LINTC_ARM && st_ff.pins.txd_o)
    else $error("time-out not followed by re-arm");
  chk_sleep_edge: assert property (@(posedge ref_clk)
    disable iff (!reset_n)
    $fell(st_ff.pins.en) |->
      $past(st_ff.pins.txd_o) && $past(st_ff.pins.txd_oe)
      ##1 st_ff.mode == LINTC_SLEEP && !st_ff.pins.txd_oe)
    else $error("enable fell without transmit high");
  chk_fs_released: assert property (@(posedge ref_clk)
    disable iff (!reset_n)
    st_ff.mode == LINTC_FAILSAFE |-> !st_ff.pins.txd_oe && !st_ff.pins.en)
    else $error("transmit pin driven in fail-safe");
  chk_wake_to_fs: assert property (@(posedge ref_clk)
    disable iff (!reset_n)
    (st_ff.mode == LINTC_SLEEP && st_ff.inh_off && pin_in.regulator_inhibit_output &&
      !cmd_normal) |=> st_ff.mode == LINTC_FAILSAFE)
    else $error("wake-up missed in sleep");
  chk_sleep_no_early: assert property (@(posedge ref_clk)
    disable iff (!reset_n)
    (st_ff.mode == LINTC_SLEEP && !st_ff.inh_off && !cmd_normal) |=>
      st_ff.mode == LINTC_SLEEP)
    else $error("left sleep before inhibit went off");
endmodule
`default_nettype wire

// ==== bench/lintc_dev.sv ====
// device model: modes, driver re-arm, time-out, wake and source code
// assumes the bench resolves the transmit wire and runs ref_clk freely
`default_nettype none
module lintc_dev #(
  parameter int REARM = 2000, // high cycles that re-arm the driver
  parameter int DOM = 100,    // low cycles that force recessive
  parameter int WAKE = 40     // wake filter cycles, shortened
) (
  input wire logic ref_clk,   // free-running reference
  input wire logic pwr_n,     // supply present
  input wire logic en,        // mode enable pin
  input wire logic txd,       // transmit wire level
  input wire logic other_dom, // another node pulls the bus low
  input wire logic wake_n,    // local wake, low active
  input wire logic uv,        // undervoltage flag
  input wire logic ot,        // over-temperature flag
  output logic txd_low,       // we pull the transmit wire low
  output logic rxd,           // receive wire after pull-up
  output logic regulator_inhibit_output,           // regulator inhibit on
  output logic bus            // bus level, 1 recessive
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] FS = 2'h0;
  localparam logic [1:0] NRM = 2'h1;
  localparam logic [1:0] SLP = 2'h2;
  logic [1:0] mode;
  logic [1:0] code; // {txd, rxd} shown in fail-safe, 2'h3 none
  logic armed;
  logic en_q;
  int hi_cnt, lo_cnt, wk_cnt, lw_cnt;
  //////////////////////////////////////////////////////////////////////
  // drive only in normal mode, armed and cool
  assign bus = !other_dom && !(mode == NRM && armed && !txd && !ot);
  // receive mirrors bus, shows source, else released
  assign rxd = (mode == NRM) ? bus : (mode == FS) ? code[0] : 1'b1;
  // transmit pin turns output in fail-safe
  assign txd_low = (mode == FS) && !code[1];
  // inhibit off only asleep or unpowered
  assign regulator_inhibit_output = pwr_n && (mode != SLP);
  //////////////////////////////////////////////////////////////////////
  // mode machine; filters are plain cycle counts to keep runs short
  always_ff @(posedge ref_clk or negedge pwr_n) begin
    if (!pwr_n) begin
      mode <= FS;
      code <= 2'h3;
      armed <= 1'b0;
      en_q <= 1'b0;
      hi_cnt <= 0;
      lo_cnt <= 0;
      wk_cnt <= 0;
      lw_cnt <= 0;
    end else begin
      en_q <= en;
      hi_cnt <= txd ? hi_cnt + 1 : 0;
      lo_cnt <= txd ? 0 : lo_cnt + 1;
      wk_cnt <= (mode == SLP && other_dom) ? wk_cnt + 1 : 0;
      lw_cnt <= (mode == SLP && !wake_n) ? lw_cnt + 1 : 0;
      if (hi_cnt >= REARM)
        armed <= 1'b1;
      if (lo_cnt >= DOM)
        armed <= 1'b0;
      case (mode)
        FS: begin
          if (uv)
            code <= 2'h2;
          if (en) begin
            mode <= NRM;
            code <= 2'h3;
          end
        end
        NRM: begin
          // undervoltage or enable fall leaves normal
          if (uv) begin
            mode <= FS;
            code <= 2'h2;
          end else if (en_q && !en && txd)
            mode <= SLP;
        end
        default: begin
          armed <= 1'b0;
          if (!other_dom && wk_cnt > WAKE) begin
            mode <= FS;
            code <= 2'h0;
          end
          if (lw_cnt > WAKE) begin
            mode <= FS;
            code <= 2'h1;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// bench top: controller against the device model, a task per scenario
// assumes the package, controller and device model compiled first
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lintc_pkg::*;
  localparam int BITC = 80; // longer than the cut: every low bit trips
  localparam int DOMC = 50;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic pwr_n = 1'b0;
  logic cmd_normal = 1'b0;
  logic cmd_sleep = 1'b0;
  logic tx_valid = 1'b0;
  logic tx_data = 1'b1;
  logic other_dom = 1'b0;
  logic wake_n = 1'b1;
  logic uv = 1'b0;
  logic ot = 1'b0;
  logic tx_ready, rx_level, link_ready, dom_timeout, txd_low, rxd, regulator_inhibit_output, bus;
  logic saw_full = 1'b0;
  logic [1:0] wake_src;
  lintc_pin_out_t pin_out;
  lintc_pin_in_t pin_in;
  int fail_count = 0;
  int samples_checked = 0;
  int dom_cnt = 0;
  int rx_cnt = 0;
  always #2.5 ref_clk = ~ref_clk;
  // transmit wire: ours while enabled, else device pull-down or pull-up
  assign pin_in = {pin_out.txd_oe ? pin_out.txd_o : !txd_low, rxd, regulator_inhibit_output};
  lintc_ctrl #(.BIT_CYCLES(BITC), .DOM_CYCLES(DOMC)) dut (
    .ref_clk, .reset_n, .cmd_normal, .cmd_sleep, .tx_valid, .tx_data,
    .tx_ready, .rx_level, .link_ready, .dom_timeout, .wake_src,
    .pin_out, .pin_in);
  lintc_dev dev (.ref_clk, .pwr_n, .en(pin_out.en), .txd(pin_in.txd),
    .other_dom, .wake_n, .uv, .ot, .txd_low, .rxd, .regulator_inhibit_output, .bus);
  //////////////////////////////////////////////////////////////////////
  // dominant cycles on the bus and on the receive report
  always @(posedge ref_clk) begin
    if (bus === 1'b0)
      dom_cnt++;
    if (rx_level === 1'b0)
      rx_cnt++;
  end
  task automatic results();
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // one cycle of a bounded wait; running out ends the run
  task automatic step(inout int n, input int lim);
    @(negedge ref_clk);
    n++;
    if (n > lim) begin
      fail_count++;
      $display("wrong value at %0t: wait ran out", $time);
      results();
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_power(input logic low_sup);
    uv = low_sup;
    pwr_n = 1'b0;
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(pin_out.en === 1'b0 && pin_out.txd_oe === 1'b0, "reset pins");
    pwr_n = 1'b1;
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(pin_in.regulator_inhibit_output === 1'b1, "inhibit at power-up");
    chk(wake_src === (low_sup ? SRC_UNDERV : SRC_NONE), "start src");
    uv = 1'b0;
  endtask
  task automatic t_normal();
    int n = 0;
    cmd_normal = 1'b1;
    @(negedge ref_clk);
    cmd_normal = 1'b0;
    chk(pin_out.en === 1'b1 && wake_src === SRC_NONE, "enter normal");
    while (link_ready !== 1'b1)
      step(n, 2100);
    chk(n == REARM_CYC, "re-arm time");
  endtask
  // push one bit; a wait here means the buffer refused
  task automatic push(input logic b);
    int n = 0;
    tx_valid = 1'b1;
    tx_data = b;
    while (tx_ready !== 1'b1) begin
      saw_full = 1'b1;
      step(n, 9000);
    end
    @(negedge ref_clk);
  endtask
  task automatic t_tx();
    int n = 0;
    dom_cnt = 0;
    rx_cnt = 0;
    push(1'b0);
    push(1'b1);
    push(1'b0);
    push(1'b0);
    tx_valid = 1'b0;
    while (dom_cnt < 3 * DOMC || link_ready !== 1'b1)
      step(n, 9000);
    chk(dom_cnt == 3 * DOMC, "dominant length");
    chk(rx_cnt >= 3 * (DOMC - 1), "receive mirror");
    chk(dom_timeout === 1'b1 && saw_full, "cut and stall");
  endtask
  // hot device keeps the bus recessive, the cut still re-arms
  task automatic t_hot();
    int n = 0;
    ot = 1'b1;
    dom_cnt = 0;
    push(1'b0);
    tx_valid = 1'b0;
    repeat (BITC) @(negedge ref_clk);
    while (link_ready !== 1'b1)
      step(n, 2100);
    chk(dom_cnt == 0 && dom_timeout === 1'b1, "hot driver off");
    ot = 1'b0;
  endtask
  task automatic t_sleep();
    cmd_sleep = 1'b1;
    @(negedge ref_clk);
    cmd_sleep = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(pin_out.en === 1'b0 && pin_out.txd_oe === 1'b0, "sleep pins");
    chk(pin_in.regulator_inhibit_output === 1'b0 && pin_in.rxd === 1'b1, "asleep");
  endtask
  task automatic t_wake(input logic remote);
    int n = 0;
    if (remote)
      other_dom = 1'b1;
    else
      wake_n = 1'b0;
    repeat (60) @(negedge ref_clk);
    if (remote)
      chk(pin_in.regulator_inhibit_output === 1'b0, "woke while dominant");
    other_dom = 1'b0;
    while (pin_in.regulator_inhibit_output !== 1'b1)
      step(n, 100);
    repeat (3) @(negedge ref_clk);
    chk(wake_src === (remote ? SRC_BUS : SRC_LOCAL), "wake source");
    wake_n = 1'b1;
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence; the bus is shorted low before the first sleep
  initial begin
    t_power(1'b0);
    t_normal();
    t_tx();
    t_hot();
    other_dom = 1'b1;
    t_sleep();
    t_wake(1'b1);
    t_normal();
    t_sleep();
    t_wake(1'b0);
    t_normal();
    t_power(1'b1);
    results();
  end
endmodule
`default_nettype wire
